// *** bench/apsb_host.sv ***
// Host model issuing single strobed register reads and writes
`timescale 1ns/100ps
module apsb_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic      [6:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial
  begin
    {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk);
    // Released lines show garbage so a late sample cannot pass
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

// *** bench/apsb_regs_asserts.sv ***
// Checker on the top module ports
`timescale 1ns/100ps
module apsb_regs_asserts (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [1:0]  page_sel,
  input wire logic        rx_burst_valid,
  input wire logic [15:0] rx_burst_len,
  input wire logic        rx_cs_wr,
  input wire logic        rx_cs_chan,
  input wire logic [4:0]  rx_cs_byte,
  input wire logic [7:0]  rx_cs_data,
  input wire logic        rx_professional
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire       pg_wr = reg_wr && reg_addr == 7'h7f;
  wire [1:0] wpg   = reg_wdata[1:0];
  wire       cs0   = rx_cs_data[0];
  wire       rd0   = reg_rd && page_sel == 2'h0;
  logic [7:0] last_hi;
  logic [7:0] last_lo;
  // Shadow of the last decoded length, so reads long after the load are judged
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      {last_hi, last_lo} <= 16'h0000;
    else if (rx_burst_valid)
      {last_hi, last_lo} <= rx_burst_len;
  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  a_read_quiet: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read answer");
  a_page_write: assert property (pg_wr |=> page_sel == $past(wpg)) else $error("page not taken");
  a_page_hold: assert property (!pg_wr |=> $stable(page_sel)) else $error("page moved");
  a_page_read: assert property (reg_rd && reg_addr == 7'h7f |=> reg_rdata == {6'h00, $past(page_sel)})
    else $error("page readback wrong");
  a_burst_high: assert property (rd0 && reg_addr == 7'h2b |=> reg_rdata == $past(last_hi))
    else $error("burst high wrong");
  a_burst_low: assert property (rd0 && reg_addr == 7'h2c |=> reg_rdata == $past(last_lo))
    else $error("burst low wrong");
  a_rsvd_page: assert property (reg_rd && page_sel == 2'h3 && reg_addr != 7'h7f |=> reg_rdata == 8'h00)
    else $error("reserved page not zero");
  a_mode_flag: assert property (rx_cs_wr && !rx_cs_chan && rx_cs_byte == 5'h00 |=> rx_professional == $past(cs0))
    else $error("mode flag wrong");
  c_page_then_read: cover property (pg_wr ##2 reg_rd);
  c_burst_load: cover property (rx_burst_valid);
  c_rsvd_read: cover property (reg_rd && page_sel == 2'h3);
endmodule
bind apsb_regs apsb_regs_asserts u_chk (.clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
  .reg_rvalid, .page_sel, .rx_burst_valid, .rx_burst_len, .rx_cs_wr, .rx_cs_chan, .rx_cs_byte, .rx_cs_data,
  .rx_professional);

// *** bench/testbench.sv ***
// Self-checking bench for the paging and buffer map registers
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; $display("Error %s exp %h got %h", n, e, a); end end
module testbench;
  logic clk, reset_n, reg_wr, reg_rd, reg_rvalid, rx_burst_valid, rx_cs_wr, rx_cs_chan, rx_professional;
  logic tx_cs_req, tx_cs_chan, tx_cs_valid, tx_professional;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rx_cs_data, tx_cs_data;
  logic [1:0]  page_sel;
  logic [15:0] rx_burst_len;
  logic [4:0]  rx_cs_byte, tx_cs_byte;
  int fails = 0;
  int compares = 0;
  typedef struct packed { logic [1:0] pg; logic [6:0] ad; logic [7:0] ex; } apsb_row_t;
  apsb_row_t rows [6] = '{'{2'h0, 7'h2b, 8'hc3}, '{2'h0, 7'h2c, 8'ha5}, '{2'h1, 7'h00, 8'h80},
                          '{2'h1, 7'h2f, 8'hf0}, '{2'h3, 7'h00, 8'h00}, '{2'h0, 7'h30, 8'h00}};
  apsb_regs dut (.clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .page_sel,
    .rx_burst_valid, .rx_burst_len, .rx_cs_wr, .rx_cs_chan, .rx_cs_byte, .rx_cs_data, .rx_professional,
    .tx_cs_req, .tx_cs_chan, .tx_cs_byte, .tx_cs_data, .tx_cs_valid, .tx_professional);
  apsb_host u_host (.clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    `CHK("rvalid", 1'b1, ok)
    `CHK("rdata", e, d)
  endtask
  task automatic rx_cs(input logic ch, input logic [4:0] b, input logic [7:0] d);
    @(negedge clk);
    {rx_cs_chan, rx_cs_byte, rx_cs_data, rx_cs_wr} = {ch, b, d, 1'b1};
    @(negedge clk);
    rx_cs_wr = 1'b0;
  endtask
  task automatic tx_chk(input logic [4:0] b, input logic [7:0] e);
    @(negedge clk);
    {tx_cs_byte, tx_cs_req} = {b, 1'b1};
    @(negedge clk);
    tx_cs_req = 1'b0;
    `CHK("tx_valid", 1'b1, tx_cs_valid)
    `CHK("tx_data", e, tx_cs_data)
  endtask
  // Bit-serial reference CRC over bytes 0-22 of one channel, first sent bit taken from the MSB
  function automatic logic [7:0] crc_of(input logic [7:0] b0, input logic [7:0] b5);
    logic [7:0] c;
    logic [7:0] d;
    c = 8'hff;
    for (int i = 0; i < 23; i++)
    begin
      d = (i == 0) ? b0 : ((i == 5) ? b5 : 8'h00);
      for (int k = 7; k >= 0; k--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? 8'h1d : 8'h00);
    end
    return c;
  endfunction
  initial
  begin
    #200us;
    fails++;
    complete_run();
  end
  initial
  begin
    {reset_n, rx_burst_valid, rx_burst_len, rx_cs_wr, rx_cs_chan, rx_cs_byte, rx_cs_data} = '0;
    {tx_cs_req, tx_cs_chan, tx_cs_byte} = '0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    rchk(7'h7f, 8'h00);
    rx_burst_len = 16'hc3a5;
    rx_burst_valid = 1'b1;
    @(negedge clk);
    rx_burst_valid = 1'b0;
    rx_cs(1'b0, 5'h00, 8'h01);
    rx_cs(1'b1, 5'h17, 8'h0f);
    `CHK("rx_prof", 1'b1, rx_professional)
    u_host.wr(7'h2b, 8'h00);
    u_host.wr(7'h7f, 8'h01);
    u_host.wr(7'h00, 8'hff);
    foreach (rows[i])
    begin
      u_host.wr(7'h7f, {6'h3f, rows[i].pg});
      rchk(7'h7f, {6'h00, rows[i].pg});
      rchk(rows[i].ad, rows[i].ex);
    end
    rx_cs(1'b0, 5'h00, 8'hfe);
    `CHK("rx_prof", 1'b0, rx_professional)
    u_host.wr(7'h7f, 8'h02);
    u_host.wr(7'h00, 8'h80);
    u_host.wr(7'h0a, 8'h5a);
    u_host.wr(7'h2e, 8'h3c);
    rchk(7'h00, 8'h80);
    `CHK("tx_prof", 1'b1, tx_professional)
    tx_chk(5'h05, 8'h5a);
    tx_chk(5'h18, 8'h00);
    repeat (50) @(negedge clk);
    tx_chk(5'h17, crc_of(8'h80, 8'h5a));
    tx_cs_chan = 1'b1;
    tx_chk(5'h17, crc_of(8'h00, 8'h00));
    tx_cs_chan = 1'b0;
    u_host.wr(7'h00, 8'h00);
    `CHK("tx_prof", 1'b0, tx_professional)
    tx_chk(5'h17, 8'h3c);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("page_sel", 2'h0, page_sel)
    rchk(7'h2b, 8'h00);
    complete_run();
  end
endmodule

// *** hdl/apsb_crc_step.sv ***
// One byte step of the channel status CRC, first sent bit in the MSB
`timescale 1ns/100ps
module apsb_crc_step (
  input  wire logic [7:0] crc_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] crc_out
);
  always_comb
  begin
    logic [7:0] acc;
    acc = crc_in;
    for (int i = 7; i >= 0; i--)
    begin
      if (acc[7] ^ data_in[i])
      begin
        acc = {acc[6:0], 1'b0} ^ apsb_pkg::CRC_POLY;
      end
      else
      begin
        acc = {acc[6:0], 1'b0};
      end
    end
    crc_out = acc;
  end
endmodule

// *** hdl/apsb_regs.sv ***
// Register paging, burst length status and channel status buffers
`timescale 1ns/100ps
module apsb_regs (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Host register port from the serial decoder
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  output logic      [1:0]  page_sel,
  // Receiver decoded burst length preamble
  input  wire logic        rx_burst_valid,
  input  wire logic [15:0] rx_burst_len,
  // Receiver channel status bytes, bit 0 first in time in data bit 0
  input  wire logic        rx_cs_wr,
  input  wire logic        rx_cs_chan,
  input  wire logic [4:0]  rx_cs_byte,
  input  wire logic [7:0]  rx_cs_data,
  output logic             rx_professional,
  // Transmitter channel status fetch
  input  wire logic        tx_cs_req,
  input  wire logic        tx_cs_chan,
  input  wire logic [4:0]  tx_cs_byte,
  output logic      [7:0]  tx_cs_data,
  output logic             tx_cs_valid,
  output logic             tx_professional
);
  logic                 rst_meta_n;
  logic                 rst_n;
  logic [15:0]          burst_length_preamble;
  logic [7:0]           rx_buf [apsb_pkg::CS_DEPTH];
  logic [7:0]           tx_buf [apsb_pkg::CS_DEPTH];
  logic [7:0]           crc_ch1;
  logic [7:0]           crc_ch2;
  logic [7:0]           crc_acc;
  logic [4:0]           walk_byte;
  apsb_pkg::apsb_walk_t walk_state;
  apsb_pkg::apsb_walk_t next_walk_state;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // Host address decode
  // The page register is matched ahead of the pages so it answers on every page
  wire       hit_page   = (reg_addr == apsb_pkg::REG_PAGE_SEL);
  wire       on_ctrl    = (page_sel == apsb_pkg::PAGE_CTRL) && !hit_page;
  wire       on_rx      = (page_sel == apsb_pkg::PAGE_RX) && !hit_page;
  wire       on_tx      = (page_sel == apsb_pkg::PAGE_TX) && !hit_page;
  wire       in_cs      = (reg_addr <= apsb_pkg::CS_LAST_ADDR);
  wire [5:0] host_idx   = reg_addr[5:0];
  wire       hit_hi     = on_ctrl && (reg_addr == apsb_pkg::REG_BURST_HI);
  wire       hit_lo     = on_ctrl && (reg_addr == apsb_pkg::REG_BURST_LO);
  wire       hit_rx_cs  = on_rx && in_cs;
  wire       hit_tx_cs  = on_tx && in_cs;
  wire       wr_page    = reg_wr && hit_page;
  wire       wr_tx_cs   = reg_wr && hit_tx_cs;
  // Page 3 and every other unmapped address read zero and drop writes

  // Read data selection
  wire [7:0] page_rdata = {apsb_pkg::PAGE_SEL_PAD, page_sel};
  wire [7:0] next_rdata = hit_page  ? page_rdata :
                          hit_hi    ? burst_length_preamble[15:8] :
                          hit_lo    ? burst_length_preamble[7:0] :
                          hit_rx_cs ? rx_buf[host_idx] :
                          hit_tx_cs ? tx_buf[host_idx] :
                                      apsb_pkg::DATA_ZERO;

  // Page register; the field alone is stored, upper bits read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      page_sel <= apsb_pkg::PAGE_SEL_RESET;
    end
    else if (wr_page)
    begin
      page_sel <= reg_wdata[1:0];
    end
  end

  // Read answer one cycle after the strobe; the data holds until the next read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
    end
  end

  // High and low burst bytes are read apart, so a load in between can tear them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= apsb_pkg::DATA_ZERO;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
    end
  end

  // Burst length status; only the receiver loads it, host writes have no path
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      burst_length_preamble <= apsb_pkg::BURST_ZERO;
    end
    else if (rx_burst_valid)
    begin
      burst_length_preamble <= rx_burst_len;
    end
  end

  // Receiver buffer, byte n of channel c at 2n+c
  wire       rx_byte_ok = (rx_cs_byte <= apsb_pkg::CS_LAST_BYTE);
  wire [5:0] rx_idx     = {rx_cs_byte, rx_cs_chan};
  wire [7:0] rx_rev;

  // Bit 0 of the received byte goes to the MSB
  genvar g;
  generate
    for (g = 0; g < apsb_pkg::DATA_W; g++)
    begin : g_rev
      assign rx_rev[apsb_pkg::DATA_W - 1 - g] = rx_cs_data[g];
    end
  endgenerate

  // Bytes past 23 are dropped so they cannot overwrite another slot
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < apsb_pkg::CS_DEPTH; i++)
      begin
        rx_buf[i] <= apsb_pkg::CS_RESET;
      end
    end
    else if (rx_cs_wr && rx_byte_ok)
    begin
      rx_buf[rx_idx] <= rx_rev;
    end
  end

  // Transmitter buffer, written by the host on page 2
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < apsb_pkg::CS_DEPTH; i++)
      begin
        tx_buf[i] <= apsb_pkg::CS_RESET;
      end
    end
    else if (wr_tx_cs)
    begin
      tx_buf[host_idx] <= reg_wdata;
    end
  end

  // Mode flags from byte 0 bit 0 of channel 1
  assign rx_professional = rx_buf[apsb_pkg::CS_MODE_IDX][apsb_pkg::CS_MODE_BIT];
  assign tx_professional = tx_buf[apsb_pkg::CS_MODE_IDX][apsb_pkg::CS_MODE_BIT];

  // Background CRC walker over bytes 0-22 of each channel in turn.
  // A host edit reaches the CRC within three channel walks, about 69 cycles; cheaper
  // than a CRC tree over 23 bytes and far faster than one frame.
  wire       walk_chan = (walk_state == apsb_pkg::WALK_CH2);
  wire [5:0] walk_idx  = {walk_byte, walk_chan};
  wire       walk_last = (walk_byte == apsb_pkg::CS_LAST_DATA);
  wire [7:0] crc_step;

  apsb_crc_step u_crc_step (
    .crc_in  (crc_acc),
    .data_in (tx_buf[walk_idx]),
    .crc_out (crc_step)
  );

  always_comb
  begin
    case (walk_state)
      apsb_pkg::WALK_CH1: next_walk_state = walk_last ? apsb_pkg::WALK_CH2 : apsb_pkg::WALK_CH1;
      apsb_pkg::WALK_CH2: next_walk_state = walk_last ? apsb_pkg::WALK_CH1 : apsb_pkg::WALK_CH2;
      default:            next_walk_state = apsb_pkg::WALK_CH1;
    endcase
  end

  // Walker next values; a channel latch takes the finished sum on byte 22
  wire [4:0] next_walk_byte = walk_last ? apsb_pkg::CS_FIRST_BYTE : walk_byte + 5'h01;
  wire [7:0] next_crc_acc   = walk_last ? apsb_pkg::CRC_INIT : crc_step;
  wire       load_ch1       = walk_last && !walk_chan;
  wire       load_ch2       = walk_last && walk_chan;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      walk_state <= apsb_pkg::WALK_CH1;
      walk_byte  <= apsb_pkg::CS_FIRST_BYTE;
      crc_acc    <= apsb_pkg::CRC_INIT;
    end
    else
    begin
      walk_state <= next_walk_state;
      walk_byte  <= next_walk_byte;
      crc_acc    <= next_crc_acc;
    end
  end

  // Until the first walk ends a latch still holds the seed value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_ch1 <= apsb_pkg::CRC_INIT;
    end
    else if (load_ch1)
    begin
      crc_ch1 <= crc_step;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_ch2 <= apsb_pkg::CRC_INIT;
    end
    else if (load_ch2)
    begin
      crc_ch2 <= crc_step;
    end
  end

  // Transmitter fetch; byte 23 carries the CRC in professional mode
  // Bytes past 23 read zero instead of wrapping into the other channel
  wire       tx_byte_ok = (tx_cs_byte <= apsb_pkg::CS_LAST_BYTE);
  wire [5:0] tx_idx     = {tx_cs_byte, tx_cs_chan};
  wire       tx_use_crc = tx_professional && (tx_cs_byte == apsb_pkg::CS_CRC_BYTE);
  wire [7:0] tx_crc     = (tx_cs_chan == apsb_pkg::CHAN_2) ? crc_ch2 : crc_ch1;
  wire [7:0] next_tx    = !tx_byte_ok ? apsb_pkg::DATA_ZERO :
                          tx_use_crc  ? tx_crc :
                                        tx_buf[tx_idx];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_cs_valid <= 1'b0;
    end
    else
    begin
      tx_cs_valid <= tx_cs_req;
    end
  end

  // Fetched byte holds until the next request, so the serialiser may take it late
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_cs_data <= apsb_pkg::DATA_ZERO;
    end
    else if (tx_cs_req)
    begin
      tx_cs_data <= next_tx;
    end
  end
endmodule

// *** inc/apsb_pkg.sv ***
// Constants and types shared by the audio page select and buffer map logic
package apsb_pkg;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned BURST_W    = 16;
  localparam int unsigned CS_IDX_W   = 6;
  localparam int unsigned CS_BYTE_W  = 5;
  localparam int unsigned PAGE_W     = 2;

  // Control page status bytes and the page register
  localparam logic [6:0] REG_BURST_HI = 7'h2b;
  localparam logic [6:0] REG_BURST_LO = 7'h2c;
  localparam logic [6:0] REG_PAGE_SEL = 7'h7f;

  // Page codes
  localparam logic [1:0] PAGE_CTRL = 2'h0;
  localparam logic [1:0] PAGE_RX   = 2'h1;
  localparam logic [1:0] PAGE_TX   = 2'h2;
  localparam logic [1:0] PAGE_RSVD = 2'h3;
  localparam logic [1:0] PAGE_SEL_RESET = 2'h0;
  localparam logic [5:0] PAGE_SEL_PAD   = 6'h00;

  // Channel status buffer layout
  localparam logic [6:0] CS_LAST_ADDR  = 7'h2f;
  localparam int unsigned CS_DEPTH     = 48;
  localparam logic [4:0] CS_LAST_BYTE  = 5'h17;
  localparam logic [4:0] CS_CRC_BYTE   = 5'h17;
  localparam logic [4:0] CS_LAST_DATA  = 5'h16;
  localparam logic [4:0] CS_FIRST_BYTE = 5'h00;
  localparam logic [5:0] CS_MODE_IDX   = 6'h00;
  localparam int unsigned CS_MODE_BIT  = 7;
  localparam logic [7:0] CS_RESET      = 8'h00;
  localparam logic       CHAN_1        = 1'b0;
  localparam logic       CHAN_2        = 1'b1;

  // Channel status CRC
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h1d;

  localparam logic [7:0]  DATA_ZERO  = 8'h00;
  localparam logic [15:0] BURST_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    WALK_CH1 = 2'b01,
    WALK_CH2 = 2'b10
  } apsb_walk_t;
endpackage
